// file: src/liu_global_consts.vh
/*
 Constants for the line interface global control register bank: register
 indices, field positions, reset values and timing counts.
 Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
*/
`ifndef LIU_GLOBAL_CONSTS_VH
`define LIU_GLOBAL_CONSTS_VH

// Channel count
`define NUM_CHANNELS 14
`define LOSS_WIDTH 6

// Register indices; byte address is four times the index
`define IDX_INT_RESET_CTRL 8'he0
`define IDX_LINE_OPTION_CTRL 8'he1
`define IDX_TERM_CABLE_LOSS_CTRL 8'he2

// Reset values
`define RST_INT_RESET_CTRL 8'h00
`define RST_LINE_OPTION_CTRL 8'h00
`define RST_TERM_CABLE_LOSS_CTRL 8'h00

// Interrupt and reset control fields
`define BIT_GLOBAL_INTERRUPT_GATE 1
`define BIT_SOFT_CIRCUIT_RESET 0

// Line option fields
`define GAUGE_MSB 5
`define GAUGE_LSB 4
`define BIT_RECEIVE_MUTE_ENABLE 2
`define BIT_EXTENDED_ZERO_COUNT 1
`define BIT_IN_CIRCUIT_TEST 0

// Gauge encodings
`define GAUGE_22_AND_24 2'h0
`define GAUGE_22 2'h1
`define GAUGE_24 2'h2
`define GAUGE_26 2'h3

// Termination and cable loss fields
`define BIT_RX_TERMINATION_SOURCE 6
`define MATCH_MSB 5
`define MATCH_LSB 0

// Soft reset hold time, least time rounded up to cycles
`define CLOCK_PERIOD_NS 10
`define SOFT_RESET_TIME_NS 10000
// Sized to the counter so the compare keeps equal widths; 10 us at 10 ns
`define SOFT_RESET_CYCLES 10'h3e8
`define SOFT_RESET_CNT_WIDTH 10

// Zero counts for digital loss of signal
`define ZERO_COUNT_NORMAL 13'h00af
`define ZERO_COUNT_EXTENDED 13'h1000
`define ZERO_CNT_WIDTH 13

`endif

// file: src/liu_global_control_regs.v
/*
 Global control register bank of a 14-channel line interface unit:
 interrupt gate, soft circuit reset, wire gauge, receive mute, digital loss
 of signal zero counting, in-circuit-test tristate, termination source and
 cable-loss match interrupt.
 Assumes channel status, receive data and bit strobes come from logic on the
 same clock; only the global termination pin is asynchronous. reset is the
 hardware reset pin, already on this clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "liu_global_consts.vh"

module liu_global_control_regs (
  // Clock and hardware reset
  input wire clock,
  input wire reset,
  // Avalon-MM register port
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Per-channel status from the channel logic
  input wire [13:0] chan_int_req,
  input wire [13:0] cable_loss_flag_enable,
  input wire [83:0] chan_cable_loss,
  input wire [13:0] receive_loss_of_signal,
  input wire [13:0] rx_termination_select,
  // Recovered receive data and bit strobes
  input wire [13:0] rx_pos_in,
  input wire [13:0] rx_neg_in,
  input wire [13:0] rx_bit_strobe,
  // Global termination pin, asynchronous
  input wire rx_termination_pin,
  // Receive data output pins
  output reg [13:0] rx_pos_out,
  output reg [13:0] rx_neg_out,
  output wire receive_data_outputs_oe,
  // Interrupt pin
  output reg interrupt_out,
  output wire interrupt_oe,
  // Configuration seen by the line circuits
  output wire gauge_22,
  output wire gauge_24,
  output wire gauge_26,
  output reg [13:0] rx_termination_active,
  output reg [13:0] digital_loss_of_signal,
  output reg [13:0] cable_loss_match,
  output reg internal_circuit_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and bus handshake

  reg [7:0] global_interrupt_reset_ctrl_r;
  reg [7:0] global_line_option_ctrl_r;
  reg [7:0] global_term_cable_loss_ctrl_r;
  reg ack_r;
  reg [31:0] readdata_nxt;
  wire aligned;
  wire [7:0] index;
  wire wr_take;
  wire sel_int_reset;
  wire sel_line_option;
  wire sel_term_cable;

  // One wait state per access; the answer edge is the one after request
  assign waitrequest = (read | write) & ~ack_r;
  assign aligned = (address[1:0] == 2'h0);
  assign index = address[9:2];
  assign sel_int_reset = aligned & (index == `IDX_INT_RESET_CTRL);
  assign sel_line_option = aligned & (index == `IDX_LINE_OPTION_CTRL);
  assign sel_term_cable = aligned & (index == `IDX_TERM_CABLE_LOSS_CTRL);
  assign wr_take = write & ack_r & byteenable[0];

  // Acknowledge toggles high for one cycle, then the master releases
  always @(posedge clock) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  // Register writes; only the hardware reset clears stored bits
  always @(posedge clock) begin
    if (reset) begin
      global_interrupt_reset_ctrl_r <= `RST_INT_RESET_CTRL;
      global_line_option_ctrl_r <= `RST_LINE_OPTION_CTRL;
      global_term_cable_loss_ctrl_r <= `RST_TERM_CABLE_LOSS_CTRL;
    end else if (wr_take) begin
      if (sel_int_reset) begin
        global_interrupt_reset_ctrl_r <= writedata[7:0];
      end
      if (sel_line_option) begin
        global_line_option_ctrl_r <= writedata[7:0];
      end
      if (sel_term_cable) begin
        global_term_cable_loss_ctrl_r <= writedata[7:0];
      end
    end
  end

  // Read mux; unmapped or misaligned addresses read zero
  always @* begin
    readdata_nxt = 32'h0000_0000;
    if (sel_int_reset) begin
      readdata_nxt = {24'h00_0000, global_interrupt_reset_ctrl_r};
    end else if (sel_line_option) begin
      readdata_nxt = {24'h00_0000, global_line_option_ctrl_r};
    end else if (sel_term_cable) begin
      readdata_nxt = {24'h00_0000, global_term_cable_loss_ctrl_r};
    end
  end

  // Read data captured in the wait cycle so it stands at the answer edge
  always @(posedge clock) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack_r) begin
      readdata <= readdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction

  wire gate_on;
  wire soft_reset_bit;
  wire [1:0] gauge_sel;
  wire mute_on;
  wire extended_on;
  wire ict_on;
  wire term_from_pin;
  wire [5:0] match_value;

  assign gate_on = global_interrupt_reset_ctrl_r[`BIT_GLOBAL_INTERRUPT_GATE];
  assign soft_reset_bit = global_interrupt_reset_ctrl_r[`BIT_SOFT_CIRCUIT_RESET];
  assign gauge_sel = global_line_option_ctrl_r[`GAUGE_MSB:`GAUGE_LSB];
  assign mute_on = global_line_option_ctrl_r[`BIT_RECEIVE_MUTE_ENABLE];
  assign extended_on = global_line_option_ctrl_r[`BIT_EXTENDED_ZERO_COUNT];
  assign ict_on = global_line_option_ctrl_r[`BIT_IN_CIRCUIT_TEST];
  assign term_from_pin = global_term_cable_loss_ctrl_r[`BIT_RX_TERMINATION_SOURCE];
  assign match_value = global_term_cable_loss_ctrl_r[`MATCH_MSB:`MATCH_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Soft circuit reset: bit must stay high for the full hold time

  reg [9:0] soft_cnt_r;
  wire soft_done;
  wire circuit_rst;

  assign soft_done = (soft_cnt_r == `SOFT_RESET_CYCLES);

  // Count while held; a short pulse never reaches the threshold
  always @(posedge clock) begin
    if (reset) begin
      soft_cnt_r <= 10'h000;
      internal_circuit_reset <= 1'b0;
    end else begin
      if (!soft_reset_bit) begin
        soft_cnt_r <= 10'h000;
      end else if (!soft_done) begin
        soft_cnt_r <= soft_cnt_r + 10'h001;
      end
      internal_circuit_reset <= soft_reset_bit & soft_done;
    end
  end

  // Circuits reset on either source; registers above ignore this
  assign circuit_rst = reset | internal_circuit_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Wire gauge decode

  // Code 00 covers both 22 and 24 gauge cable
  assign gauge_22 = (gauge_sel == `GAUGE_22_AND_24) | (gauge_sel == `GAUGE_22);
  assign gauge_24 = (gauge_sel == `GAUGE_22_AND_24) | (gauge_sel == `GAUGE_24);
  assign gauge_26 = (gauge_sel == `GAUGE_26);

  ////////////////////////////////////////////////////////////////////////////
  // Termination pin synchroniser and source select

  reg term_pin_meta_r;
  reg term_pin_sync_r;

  // Two flops; only the second is read by logic
  always @(posedge clock) begin
    if (reset) begin
      term_pin_meta_r <= 1'b0;
      term_pin_sync_r <= 1'b0;
    end else begin
      term_pin_meta_r <= rx_termination_pin;
      term_pin_sync_r <= term_pin_meta_r;
    end
  end

  // Pin drives all channels at once when selected
  always @(posedge clock) begin
    if (circuit_rst) begin
      rx_termination_active <= 14'h0000;
    end else if (term_from_pin) begin
      rx_termination_active <= {14{term_pin_sync_r}};
    end else begin
      rx_termination_active <= rx_termination_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel logic: cable loss match, receive mute, zero counting

  wire [12:0] zero_threshold;

  // Threshold switch takes effect on the next bit strobe
  assign zero_threshold = extended_on ? `ZERO_COUNT_EXTENDED : `ZERO_COUNT_NORMAL;

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1) begin : chan
      reg [12:0] zero_cnt_r;
      wire line_zero;
      wire [5:0] loss_word;

      assign line_zero = ~rx_pos_in[ch] & ~rx_neg_in[ch];
      assign loss_word = chan_cable_loss[ch * `LOSS_WIDTH +: `LOSS_WIDTH];

      // Match is registered; compare holds while values stay equal
      always @(posedge clock) begin
        if (circuit_rst) begin
          cable_loss_match[ch] <= 1'b0;
        end else begin
          cable_loss_match[ch] <= cable_loss_flag_enable[ch] & (loss_word == match_value);
        end
      end

      // Muted data pulled low only on channels in loss of signal
      always @(posedge clock) begin
        if (circuit_rst) begin
          rx_pos_out[ch] <= 1'b0;
          rx_neg_out[ch] <= 1'b0;
        end else if (mute_on & receive_loss_of_signal[ch]) begin
          rx_pos_out[ch] <= 1'b0;
          rx_neg_out[ch] <= 1'b0;
        end else begin
          rx_pos_out[ch] <= rx_pos_in[ch];
          rx_neg_out[ch] <= rx_neg_in[ch];
        end
      end

      // Consecutive zeros counted per recovered bit; a mark restarts
      always @(posedge clock) begin
        if (circuit_rst) begin
          zero_cnt_r <= 13'h0000;
          digital_loss_of_signal[ch] <= 1'b0;
        end else if (rx_bit_strobe[ch]) begin
          if (!line_zero) begin
            zero_cnt_r <= 13'h0000;
            digital_loss_of_signal[ch] <= 1'b0;
          end else begin
            if (zero_cnt_r < zero_threshold) begin
              zero_cnt_r <= zero_cnt_r + 13'h0001;
            end
            // Declared when this zero brings the run to the threshold
            digital_loss_of_signal[ch] <= (zero_cnt_r + 13'h0001 >= zero_threshold);
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin and output enables

  // Gate masks every source, so nothing reaches the pin while low
  always @(posedge clock) begin
    if (circuit_rst) begin
      interrupt_out <= 1'b0;
    end else begin
      interrupt_out <= gate_on & (|(chan_int_req | cable_loss_match));
    end
  end

  // Test mode floats every pin; data flops keep running underneath
  assign receive_data_outputs_oe = ~ict_on;
  assign interrupt_oe = ~ict_on;

endmodule
`default_nettype wire

// file: tb/liu_regs_chk_asserts.sv
/* Port checker for the global control register bank.
 Sees only the top module ports; one clock, synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
`include "liu_global_consts.vh"
module liu_regs_chk (
  // Clock, reset and bus
  input wire logic clock,
  input wire logic reset,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [9:0] address,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  // Channel inputs
  input wire logic [13:0] chan_int_req,
  input wire logic [13:0] cable_loss_flag_enable,
  input wire logic [13:0] receive_loss_of_signal,
  input wire logic [13:0] rx_termination_select,
  input wire logic [13:0] rx_pos_in,
  input wire logic [13:0] rx_bit_strobe,
  // Outputs watched
  input wire logic [13:0] rx_pos_out,
  input wire logic receive_data_outputs_oe,
  input wire logic interrupt_oe,
  input wire logic interrupt_out,
  input wire logic gauge_22,
  input wire logic gauge_24,
  input wire logic gauge_26,
  input wire logic [13:0] rx_termination_active,
  input wire logic [13:0] digital_loss_of_signal,
  input wire logic [13:0] cable_loss_match,
  input wire logic internal_circuit_reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Cycles since last accepted write; soft reset must follow a long hold
  logic [9:0] wcnt_r;
  always @(posedge clock) begin
    if (reset || (write && !waitrequest))
      wcnt_r <= 10'h000;
    else if (wcnt_r != 10'h3ff)
      wcnt_r <= wcnt_r + 10'h001;
  end
  // Shadow copies of the registers, updated on the accepting edge
  logic [7:0] int_sh;
  logic [7:0] line_sh;
  logic [7:0] term_sh;
  always @(posedge clock) begin
    if (reset) begin
      int_sh <= 8'h00;
      line_sh <= 8'h00;
      term_sh <= 8'h00;
    end else if (write && !waitrequest && byteenable[0]) begin
      if (address == {`IDX_INT_RESET_CTRL, 2'h0})
        int_sh <= writedata[7:0];
      if (address == {`IDX_LINE_OPTION_CTRL, 2'h0})
        line_sh <= writedata[7:0];
      if (address == {`IDX_TERM_CABLE_LOSS_CTRL, 2'h0})
        term_sh <= writedata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_int_cause;
    interrupt_out |-> $past(|(chan_int_req | cable_loss_match));
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without a cause");
  property p_gate;
    !$past(int_sh[`BIT_GLOBAL_INTERRUPT_GATE]) |-> !interrupt_out;
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt while gate closed");
  property p_int_pass;
    $past(int_sh[`BIT_GLOBAL_INTERRUPT_GATE]) && $past(|(chan_int_req | cable_loss_match)) &&
      !$past(reset) && !$past(internal_circuit_reset) |-> interrupt_out;
  endproperty
  a_int_pass: assert property (p_int_pass) else $error("interrupt request lost");
  property p_mute;
    !$past(reset) && !$past(internal_circuit_reset) && !internal_circuit_reset |->
      ((rx_pos_out ^ $past(rx_pos_in)) & ~$past(receive_loss_of_signal)) == 14'h0000;
  endproperty
  a_mute: assert property (p_mute) else $error("unmuted channel data wrong");
  property p_mute_low;
    (rx_pos_out & (~$past(rx_pos_in) |
      ($past(receive_loss_of_signal) & {14{$past(line_sh[`BIT_RECEIVE_MUTE_ENABLE])}}))) == 14'h0000;
  endproperty
  a_mute_low: assert property (p_mute_low) else $error("receive data invented");
  property p_gauge;
    ($onehot({gauge_22, gauge_24, gauge_26}) || (gauge_22 && gauge_24 && !gauge_26)) &&
      ({gauge_22, gauge_24, gauge_26} ==
      ((line_sh[`GAUGE_MSB:`GAUGE_LSB] == `GAUGE_22_AND_24) ? 3'h6 :
      (line_sh[`GAUGE_MSB:`GAUGE_LSB] == `GAUGE_22) ? 3'h4 :
      (line_sh[`GAUGE_MSB:`GAUGE_LSB] == `GAUGE_24) ? 3'h2 : 3'h1));
  endproperty
  a_gauge: assert property (p_gauge) else $error("gauge decode illegal");
  property p_oe_pair;
    receive_data_outputs_oe == interrupt_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("output enables disagree");
  property p_ict;
    (receive_data_outputs_oe == !line_sh[`BIT_IN_CIRCUIT_TEST]) &&
      (interrupt_oe == !line_sh[`BIT_IN_CIRCUIT_TEST]);
  endproperty
  a_ict: assert property (p_ict) else $error("test tristate does not follow bit");
  property p_match;
    (cable_loss_match & ~$past(cable_loss_flag_enable)) == 14'h0000;
  endproperty
  a_match: assert property (p_match) else $error("match on disabled channel");
  property p_soft;
    $rose(internal_circuit_reset) |-> wcnt_r >= 10'h3e7;
  endproperty
  a_soft: assert property (p_soft) else $error("circuit reset too early");
  property p_term;
    ($past(term_sh[`BIT_RX_TERMINATION_SOURCE]) || $past(reset) || $past(internal_circuit_reset) ||
      rx_termination_active == $past(rx_termination_select)) &&
      (rx_termination_active == $past(rx_termination_select) || rx_termination_active == 14'h0000 ||
      rx_termination_active == 14'h3fff);
  endproperty
  a_term: assert property (p_term) else $error("termination source mixed");
  property p_dlos;
    (digital_loss_of_signal & ~$past(digital_loss_of_signal) & ~$past(rx_bit_strobe)) == 14'h0000;
  endproperty
  a_dlos: assert property (p_dlos) else $error("loss declared without strobe");
  // Main scenarios reached
  c_soft: cover property ($rose(internal_circuit_reset));
  c_dlos: cover property (|digital_loss_of_signal);
  c_match: cover property (|cable_loss_match && interrupt_out);
endmodule
bind liu_global_control_regs liu_regs_chk liu_regs_chk_i (.*);
`default_nettype wire

// file: tb/tb_liu_global_control_regs.sv
/* Self-checking bench for the global control register bank.
 Drives every port directly; Avalon-MM master with one wait cycle expected. */
`timescale 1ns/100ps
`default_nettype none
`include "liu_global_consts.vh"
module tb_liu_global_control_regs;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] readdata;
  logic waitrequest;
  logic [13:0] chan_int_req = 14'h0, cable_loss_flag_enable = 14'h0, receive_loss_of_signal = 14'h0;
  logic [13:0] rx_termination_select = 14'h0, rx_pos_in = 14'h0, rx_neg_in = 14'h0, rx_bit_strobe = 14'h0;
  logic [83:0] chan_cable_loss = 84'h0;
  logic rx_termination_pin = 1'b0;
  logic [13:0] rx_pos_out, rx_neg_out, rx_termination_active, digital_loss_of_signal, cable_loss_match;
  logic receive_data_outputs_oe, interrupt_out, interrupt_oe, gauge_22, gauge_24, gauge_26;
  logic internal_circuit_reset;
  int n_fail = 0;
  int tests_run = 0;
  int g;
  liu_global_control_regs liu_global_control_regs_i (.*);
  // Clock at 100 MHz
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    // Ends on the edge; reads then see the values settled before it
    repeat (n) @(posedge clock);
  endtask
  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clock);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, wd};
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk("readdata", d, exp);
  endtask
  // Strobe n bits of value v on every channel, then check loss state
  task automatic strobes(input int n, input logic v, input logic [13:0] exp);
    repeat (n) begin
      @(posedge clock);
      rx_bit_strobe <= 14'h3fff;
      rx_pos_in <= {14{v}};
      rx_neg_in <= 14'h0000;
      @(posedge clock);
      rx_bit_strobe <= 14'h0000;
    end
    tick(1);
    chk("digital_loss", digital_loss_of_signal, exp);
  endtask
  task automatic complete_run;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Hang guard, well past the roughly 10k cycles the tests need
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
  initial begin
    tick(16);
    reset <= 1'b0;
    for (g = 0; g < 3; g++) rchk(8'he0 + g[7:0], 32'h0);
    wr(8'he1, 8'hc8);
    rchk(8'he1, 32'hc8);
    rchk(8'h10, 32'h0);
    for (g = 0; g < 4; g++) begin
      wr(8'he1, {2'b00, g[1:0], 4'h0});
      tick(1);
      chk("gauge", {gauge_22, gauge_24, gauge_26}, {~g[1], ~g[0], &g[1:0]});
    end
    wr(8'he1, 8'h01);
    tick(1);
    chk("oe", {receive_data_outputs_oe, interrupt_oe}, 2'b00);
    @(posedge clock);
    rx_pos_in <= 14'h3fff;
    rx_neg_in <= 14'h3fff;
    receive_loss_of_signal <= 14'h0001;
    wr(8'he1, 8'h04);
    tick(2);
    chk("oe", {receive_data_outputs_oe, interrupt_oe}, 2'b11);
    chk("rx_out", {rx_pos_out, rx_neg_out}, {14'h3ffe, 14'h3ffe});
    wr(8'he1, 8'h00);
    tick(2);
    chk("rx_out", {rx_pos_out, rx_neg_out}, {14'h3fff, 14'h3fff});
    chan_int_req <= 14'h2000;
    tick(2);
    chk("interrupt", interrupt_out, 1'b0);
    wr(8'he0, 8'h02);
    tick(2);
    chk("interrupt", interrupt_out, 1'b1);
    @(posedge clock);
    chan_int_req <= 14'h0;
    chan_cable_loss <= 84'h2a << 18;
    cable_loss_flag_enable <= 14'h0008;
    wr(8'he2, 8'h2a);
    tick(3);
    chk("match", {cable_loss_match, interrupt_out}, {14'h0008, 1'b1});
    wr(8'he2, 8'h2b);
    tick(3);
    chk("match", {cable_loss_match, interrupt_out}, {14'h0000, 1'b0});
    wr(8'he0, 8'h00);
    @(posedge clock);
    rx_termination_select <= 14'h1234;
    rx_termination_pin <= 1'b1;
    tick(2);
    chk("term", rx_termination_active, 14'h1234);
    wr(8'he2, 8'h40);
    tick(4);
    chk("term", rx_termination_active, 14'h3fff);
    wr(8'he1, 8'h02);
    strobes(`ZERO_COUNT_EXTENDED - 1, 1'b0, 14'h0);
    strobes(1, 1'b0, 14'h3fff);
    strobes(1, 1'b1, 14'h0);
    wr(8'he1, 8'h30);
    strobes(`ZERO_COUNT_NORMAL - 1, 1'b0, 14'h0);
    strobes(1, 1'b0, 14'h3fff);
    wr(8'he0, 8'h01);
    tick(900);
    chk("soft_reset", internal_circuit_reset, 1'b0);
    tick(200);
    chk("soft_reset", internal_circuit_reset, 1'b1);
    rchk(8'he1, 32'h30);
    wr(8'he0, 8'h00);
    tick(2);
    chk("soft_reset", internal_circuit_reset, 1'b0);
    // Only the hardware reset restores register defaults
    reset <= 1'b1;
    tick(16);
    reset <= 1'b0;
    rchk(8'he1, 32'h0);
    rchk(8'he2, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
